/* design/lbc_ctrl.sv */
// Host controller driving the command and clock-enable pins of the DRAM
`timescale 1ns/1ps
module lbc_ctrl #(
  parameter int BURST_LEN = 4,
  parameter int CAS_LAT = 3,
  parameter int NB = 4
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic req_valid_in,
  input wire logic [3:0] req_cmd_in,
  input wire logic [1:0] req_bank_in,
  input wire logic req_ap_in,
  input wire logic [12:0] req_addr_in,
  input wire logic [3:0] req_mask_in,
  output logic req_done_out,
  output logic cke_out,
  output logic cs_n_out,
  output logic ras_n_out,
  output logic cas_n_out,
  output logic we_n_out,
  output logic [1:0] ba_out,
  output logic [12:0] addr_out,
  output logic [3:0] write_byte_mask_out,
  output logic [2:0] pwr_state_out,
  output logic need_init_out
);

  localparam int HB = BURST_LEN / 2;
  localparam int RD2WR = CAS_LAT + HB;
  localparam int WR2RD = 1 + HB + lbc_pkg::WTR_CK;
  localparam int WRR = HB + lbc_pkg::WR_CYC;

  lbc_pkg::lbc_ctrl_s s;
  lbc_pkg::lbc_ctrl_s next_s;
  lbc_pkg::lbc_req_e req;
  logic p_act, p_rd, p_wr, p_pre, p_all, p_ref, p_lmr, p_bst;
  logic [NB-1:0] b_act, b_rd, b_wr, b_pre;
  logic [NB-1:0] b_idle, b_open, b_settled, b_rw, b_cpre;
  logic legal, go, all_idle;

  assign req = lbc_pkg::lbc_req_e'(req_cmd_in);

  // ------------------------------------------------------------
  // Decode of the command now on the pins
  // ------------------------------------------------------------
  assign p_act = s.cke && s.cmd == lbc_pkg::PIN_ACT;
  assign p_rd = s.cke && s.cmd == lbc_pkg::PIN_RD;
  assign p_wr = s.cke && s.cmd == lbc_pkg::PIN_WR;
  assign p_pre = s.cke && s.cmd == lbc_pkg::PIN_PRE;
  assign p_all = p_pre && s.addr[lbc_pkg::AP_BIT];
  assign p_ref = s.cke && s.cmd == lbc_pkg::PIN_REF;
  assign p_lmr = s.cke && s.cmd == lbc_pkg::PIN_LMR;
  assign p_bst = s.cke && s.cmd == lbc_pkg::PIN_BST;
  assign all_idle = &b_idle;

  always_comb begin
    for (int i = 0; i < NB; i++) begin
      b_act[i] = p_act && s.ba == 2'(i);
      b_rd[i] = p_rd && s.ba == 2'(i);
      b_wr[i] = p_wr && s.ba == 2'(i);
      b_pre[i] = p_pre && (p_all || s.ba == 2'(i));
    end
  end

  // ------------------------------------------------------------
  // Bank trackers
  // ------------------------------------------------------------
  for (genvar g = 0; g < NB; g++) begin : g_bank
    lbc_bank #(
      .HB(HB),
      .RCD(lbc_pkg::RCD_CYC),
      .RP(lbc_pkg::RP_CYC),
      .WRR(WRR)
    ) u_bank (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .act_in(b_act[g]),
      .rd_in(b_rd[g]),
      .wr_in(b_wr[g]),
      .pre_in(b_pre[g] && b_cpre[g]),
      .ap_in(s.addr[lbc_pkg::AP_BIT]),
      .bst_in(p_bst),
      .idle_out(b_idle[g]),
      .open_out(b_open[g]),
      .settled_out(b_settled[g]),
      .can_rw_out(b_rw[g]),
      .can_pre_out(b_cpre[g])
    );
  end

  // ------------------------------------------------------------
  // Legality of the pending request
  // ------------------------------------------------------------
  always_comb begin
    legal = 1'b0;
    case (req)
      lbc_pkg::Q_ACT: legal = b_idle[req_bank_in] && !s.need_init;
      lbc_pkg::Q_RD: legal = b_rw[req_bank_in] && s.c_rd == 8'h00 &&
        !s.need_init;
      lbc_pkg::Q_WR: legal = b_rw[req_bank_in] && s.c_wr == 8'h00 &&
        !s.need_init;
      lbc_pkg::Q_PRE: legal = b_cpre[req_bank_in] && !s.need_init;
      lbc_pkg::Q_PREALL: legal = &(b_cpre | b_idle);
      lbc_pkg::Q_REF: legal = all_idle;
      lbc_pkg::Q_LMR: legal = all_idle;
      lbc_pkg::Q_BST: legal = !s.need_init;
      lbc_pkg::Q_PD: legal = &b_settled && s.c_wr == 8'h00 &&
        s.c_rd == 8'h00 && !s.need_init;
      lbc_pkg::Q_SR: legal = all_idle && !s.need_init;
      lbc_pkg::Q_DEEP: legal = all_idle;
      lbc_pkg::Q_INIT_DONE: legal = s.need_init && all_idle;
      default: legal = 1'b0;
    endcase
    if (s.c_blk != 8'h00) legal = 1'b0;
  end

  // ------------------------------------------------------------
  // Main state update
  // ------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.cmd = lbc_pkg::PIN_NOP;
    next_s.wmask = 4'h0;
    if (s.c_rd != 8'h00) next_s.c_rd = s.c_rd - 8'h01;
    if (s.c_wr != 8'h00) next_s.c_wr = s.c_wr - 8'h01;
    if (s.c_blk != 8'h00) next_s.c_blk = s.c_blk - 8'h01;
    if (s.c_ex != 8'h00) next_s.c_ex = s.c_ex - 8'h01;
    if (p_rd) begin
      next_s.c_rd = 8'(HB - 1);
      next_s.c_wr = 8'(RD2WR - 1);
    end
    if (p_wr) begin
      next_s.c_rd = 8'(WR2RD - 1);
      next_s.c_wr = 8'(HB - 1);
    end
    if (p_bst) next_s.c_wr = 8'h00;
    if (p_ref) next_s.c_blk = 8'(lbc_pkg::RFC_CYC - 1);
    if (p_lmr) next_s.c_blk = 8'(lbc_pkg::TMRD_CK - 1);
    go = req_valid_in && !s.done;
    case (s.pwr)
      lbc_pkg::P_RUN: begin
        // Clock enable stays high on both edges here except on a power-down, self-refresh or deep-sleep entry
        if (go && legal) begin
          next_s.done = 1'b1;
          next_s.ba = req_bank_in;
          next_s.addr = req_addr_in;
          case (req)
            lbc_pkg::Q_ACT: next_s.cmd = lbc_pkg::PIN_ACT;
            lbc_pkg::Q_RD: begin
              next_s.cmd = lbc_pkg::PIN_RD;
              next_s.addr[lbc_pkg::AP_BIT] = req_ap_in;
            end
            lbc_pkg::Q_WR: begin
              next_s.cmd = lbc_pkg::PIN_WR;
              next_s.addr[lbc_pkg::AP_BIT] = req_ap_in;
              next_s.wmask = req_mask_in;
            end
            lbc_pkg::Q_PRE, lbc_pkg::Q_PREALL: begin
              next_s.cmd = lbc_pkg::PIN_PRE;
              next_s.addr[lbc_pkg::AP_BIT] = (req == lbc_pkg::Q_PREALL);
            end
            lbc_pkg::Q_REF: next_s.cmd = lbc_pkg::PIN_REF;
            lbc_pkg::Q_LMR: next_s.cmd = lbc_pkg::PIN_LMR;
            lbc_pkg::Q_BST: next_s.cmd = lbc_pkg::PIN_BST;
            lbc_pkg::Q_PD: begin
              next_s.cke = 1'b0;
              next_s.pwr = (|b_open) ? lbc_pkg::P_APD : lbc_pkg::P_PPD;
            end
            lbc_pkg::Q_SR: begin
              next_s.cke = 1'b0;
              next_s.cmd = lbc_pkg::PIN_REF;
              next_s.pwr = lbc_pkg::P_SR;
            end
            lbc_pkg::Q_DEEP: begin
              next_s.cke = 1'b0;
              next_s.cmd = lbc_pkg::PIN_BST;
              next_s.pwr = lbc_pkg::P_DEEP;
            end
            lbc_pkg::Q_INIT_DONE: next_s.need_init = 1'b0;
            default: next_s.done = 1'b0;
          endcase
        end
      end
      lbc_pkg::P_PPD, lbc_pkg::P_APD, lbc_pkg::P_SR, lbc_pkg::P_DEEP: begin
        // Held low with NOP until a wake request
        if (go && req == lbc_pkg::Q_WAKE) begin
          next_s.cke = 1'b1;
          next_s.done = 1'b1;
          next_s.pwr = lbc_pkg::P_EXIT;
          next_s.c_ex = (s.pwr == lbc_pkg::P_SR) ?
            8'(lbc_pkg::XSR_CYC - 1) : 8'(lbc_pkg::XP_CYC - 1);
          if (s.pwr == lbc_pkg::P_DEEP) next_s.need_init = 1'b1;
        end
      end
      lbc_pkg::P_EXIT: begin
        if (s.c_ex == 8'h00) next_s.pwr = lbc_pkg::P_RUN;
      end
      default: next_s.pwr = lbc_pkg::P_RUN;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s <= lbc_pkg::CTRL_RST;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign req_done_out = s.done;
  assign cke_out = s.cke;
  assign cs_n_out = s.cmd[3];
  assign ras_n_out = s.cmd[2];
  assign cas_n_out = s.cmd[1];
  assign we_n_out = s.cmd[0];
  assign ba_out = s.ba;
  assign addr_out = s.addr;
  assign write_byte_mask_out = s.wmask;
  assign pwr_state_out = s.pwr;
  assign need_init_out = s.need_init;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [7:0] since_rd, since_wr;
  logic is_nop;

  assign is_nop = s.cmd == lbc_pkg::PIN_NOP || s.cmd[3];

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      since_rd <= 8'hFF;
      since_wr <= 8'hFF;
    end else begin
      since_rd <= p_rd ? 8'h01 : p_bst ? 8'hFF :
        (since_rd == 8'hFF) ? since_rd : since_rd + 8'h01;
      since_wr <= p_wr ? 8'h01 :
        (since_wr == 8'hFF) ? since_wr : since_wr + 8'h01;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  sequence s_wake;
    !s.cke ##1 s.cke;
  endsequence

  chk_wr_after_rd: assert property (p_wr |-> since_rd >= 8'(RD2WR))
    else $error("write too soon after read");
  chk_rd_after_wr: assert property (p_rd |-> since_wr >= 8'(WR2RD))
    else $error("read too soon after write");
  chk_rd_spacing: assert property (p_rd |-> since_rd >= 8'(HB))
    else $error("reads closer than half burst");
  chk_ref_all_idle: assert property (p_ref |-> $past(all_idle))
    else $error("refresh with a bank not idle");
  chk_low_stays_nop: assert property (!s.cke && $past(!s.cke) |-> is_nop)
    else $error("command while clock enable low");
  chk_wake_quiet: assert property (s_wake |-> is_nop ##1 is_nop)
    else $error("command during exit delay");
  chk_sr_entry_idle: assert property ($fell(s.cke) &&
    s.cmd == lbc_pkg::PIN_REF |-> $past(all_idle))
    else $error("self refresh entry with open bank");
  chk_init_gate: assert property (s.need_init |->
    !(p_act || p_rd || p_wr))
    else $error("normal command before initialization");
  chk_done_pulse: assert property (s.done |=> !s.done)
    else $error("done held longer than one cycle");

endmodule : lbc_ctrl

/* design/lbc_pkg.sv */
// Shared constants and types for the low-power DRAM host controller
package lbc_pkg;

  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int TCK_NS = 100;
  localparam int ACT_ACC_NS = 15;
  localparam int PRECH_NS = 15;
  localparam int WREC_NS = 15;
  localparam int PDX_NS = 25;
  localparam int SRX_NS = 112;
  localparam int TRFC_NS = 72;
  localparam int TMRD_CK = 2;
  localparam int WTR_CK = 1;
  localparam int XSR_MIN_CK = 2;
  localparam int RCD_CYC = (ACT_ACC_NS + TCK_NS - 1) / TCK_NS;
  localparam int RP_CYC = (PRECH_NS + TCK_NS - 1) / TCK_NS;
  localparam int WR_CYC = (WREC_NS + TCK_NS - 1) / TCK_NS;
  localparam int XP_CYC = (PDX_NS + TCK_NS - 1) / TCK_NS;
  localparam int XSR_RAW = (SRX_NS + TCK_NS - 1) / TCK_NS;
  localparam int XSR_CYC = (XSR_RAW < XSR_MIN_CK) ? XSR_MIN_CK : XSR_RAW;
  localparam int RFC_CYC = (TRFC_NS + TCK_NS - 1) / TCK_NS;

  // ------------------------------------------------------------
  // Pin widths and fields
  // ------------------------------------------------------------
  localparam int BA_W = 2;
  localparam int A_W = 13;
  localparam int WMASK_W = 4;
  localparam int AP_BIT = 10;

  // Command pins {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] PIN_DESEL = 4'hF;
  localparam logic [3:0] PIN_NOP = 4'h7;
  localparam logic [3:0] PIN_ACT = 4'h3;
  localparam logic [3:0] PIN_RD = 4'h5;
  localparam logic [3:0] PIN_WR = 4'h4;
  localparam logic [3:0] PIN_PRE = 4'h2;
  localparam logic [3:0] PIN_REF = 4'h1;
  localparam logic [3:0] PIN_LMR = 4'h0;
  localparam logic [3:0] PIN_BST = 4'h6;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    Q_NOP = 4'h0, Q_ACT = 4'h1, Q_RD = 4'h2, Q_WR = 4'h3,
    Q_PRE = 4'h4, Q_PREALL = 4'h5, Q_REF = 4'h6, Q_LMR = 4'h7,
    Q_BST = 4'h8, Q_PD = 4'h9, Q_SR = 4'hA, Q_DEEP = 4'hB,
    Q_WAKE = 4'hC, Q_INIT_DONE = 4'hD
  } lbc_req_e;

  typedef enum logic [2:0] {
    P_RUN = 3'h0, P_PPD = 3'h1, P_APD = 3'h3, P_SR = 3'h2,
    P_DEEP = 3'h6, P_EXIT = 3'h4
  } lbc_pwr_e;

  typedef enum logic [2:0] {
    B_IDLE = 3'h0, B_ACTING = 3'h1, B_ACTIVE = 3'h3, B_READ = 3'h2,
    B_WRITE = 3'h6, B_PRE = 3'h4
  } lbc_bank_e;

  typedef struct packed {
    lbc_bank_e st;
    logic ap;
    logic [7:0] cnt;
  } lbc_bank_s;

  typedef struct packed {
    lbc_pwr_e pwr;
    logic cke;
    logic [3:0] cmd;
    logic [BA_W-1:0] ba;
    logic [A_W-1:0] addr;
    logic [WMASK_W-1:0] wmask;
    logic done;
    logic need_init;
    logic [7:0] c_rd;
    logic [7:0] c_wr;
    logic [7:0] c_blk;
    logic [7:0] c_ex;
  } lbc_ctrl_s;

  localparam lbc_bank_s BANK_RST = '{st: B_IDLE, ap: 1'b0, cnt: 8'h00};
  localparam lbc_ctrl_s CTRL_RST = '{pwr: P_RUN, cke: 1'b1,
    cmd: PIN_NOP, ba: 2'h0, addr: 13'h0000, wmask: 4'h0, done: 1'b0,
    need_init: 1'b1, c_rd: 8'h00, c_wr: 8'h00, c_blk: 8'h00,
    c_ex: 8'h00};

endpackage : lbc_pkg

/* design/lbc_bank.sv */
// Per-bank state tracker with its own delay counter
`timescale 1ns/1ps
module lbc_bank #(
  parameter int HB = 2,
  parameter int RCD = 1,
  parameter int RP = 1,
  parameter int WRR = 3
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic act_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic pre_in,
  input wire logic ap_in,
  input wire logic bst_in,
  output logic idle_out,
  output logic open_out,
  output logic settled_out,
  output logic can_rw_out,
  output logic can_pre_out
);

  lbc_pkg::lbc_bank_s s;
  lbc_pkg::lbc_bank_s next_s;

  // ------------------------------------------------------------
  // State update
  // ------------------------------------------------------------
  always_comb begin
    next_s = s;
    if (s.cnt != 8'h00) begin
      next_s.cnt = s.cnt - 8'h01;
    end
    case (s.st)
      lbc_pkg::B_IDLE: begin
        if (act_in) begin
          next_s.st = lbc_pkg::B_ACTING;
          next_s.cnt = 8'(RCD - 1);
        end
      end
      lbc_pkg::B_ACTING: begin
        if (s.cnt == 8'h00) next_s.st = lbc_pkg::B_ACTIVE;
      end
      lbc_pkg::B_PRE: begin
        if (s.cnt == 8'h00) next_s.st = lbc_pkg::B_IDLE;
      end
      lbc_pkg::B_READ, lbc_pkg::B_WRITE: begin
        // Auto precharge starts where a manual one would have
        if (s.cnt == 8'h00 ||
            (bst_in && s.st == lbc_pkg::B_READ && !s.ap)) begin
          next_s.st = s.ap ? lbc_pkg::B_PRE : lbc_pkg::B_ACTIVE;
          next_s.cnt = 8'(RP - 1);
        end
      end
      lbc_pkg::B_ACTIVE: begin
      end
      default: next_s.st = lbc_pkg::B_IDLE;
    endcase
    if (rd_in || wr_in) begin
      next_s.st = rd_in ? lbc_pkg::B_READ : lbc_pkg::B_WRITE;
      next_s.ap = ap_in;
      next_s.cnt = rd_in ? 8'(HB - 1) : 8'(WRR);
    end
    if (pre_in) begin
      next_s.st = lbc_pkg::B_PRE;
      next_s.ap = 1'b0;
      next_s.cnt = 8'(RP - 1);
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s <= lbc_pkg::BANK_RST;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------
  // Status
  // ------------------------------------------------------------
  assign idle_out = (s.st == lbc_pkg::B_IDLE);
  assign open_out = !(s.st == lbc_pkg::B_IDLE || s.st == lbc_pkg::B_PRE);
  assign settled_out = idle_out || s.st == lbc_pkg::B_ACTIVE;
  assign can_rw_out = (s.st == lbc_pkg::B_ACTIVE) ||
    ((s.st == lbc_pkg::B_READ || s.st == lbc_pkg::B_WRITE) && !s.ap);
  assign can_pre_out = (s.st == lbc_pkg::B_ACTIVE) ||
    (s.st == lbc_pkg::B_READ && !s.ap);

endmodule : lbc_bank

/* verification/lbc_dev_model.sv */
// Behavioural four-bank DRAM that counts command-rule violations
`timescale 1ns/1ps
module lbc_dev_model #(
  parameter int BURST_LEN = 4,
  parameter int CAS_LAT = 3
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic cke_in,
  input wire logic cs_n_in,
  input wire logic ras_n_in,
  input wire logic cas_n_in,
  input wire logic we_n_in,
  input wire logic [1:0] ba_in,
  input wire logic [12:0] addr_in,
  output logic low_power_out,
  output logic [7:0] viol_out
);
  logic cke_prev;
  logic [3:0] open;
  logic need_init;
  logic sr;
  logic [3:0] c;
  int rd_left;
  int wr_left;
  int ex_left;
  // Chip select high decodes as deselect
  assign c = cs_n_in ? 4'hF : {1'b0, ras_n_in, cas_n_in, we_n_in};
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cke_prev <= 1'b1;
      open <= 4'h0;
      need_init <= 1'b1;
      sr <= 1'b0;
      rd_left <= 0;
      wr_left <= 0;
      ex_left <= 0;
      low_power_out <= 1'b0;
      viol_out <= 8'h00;
    end else begin
      cke_prev <= cke_in;
      if (rd_left > 0) rd_left <= rd_left - 1;
      if (wr_left > 0) wr_left <= wr_left - 1;
      if (ex_left > 0) ex_left <= ex_left - 1;
      if (!cke_prev && !cke_in) begin
        low_power_out <= 1'b1;
      end else if (!cke_prev) begin
        low_power_out <= 1'b0;
        if (c != 4'hF && c != 4'h7) viol_out <= viol_out + 8'h01;
        ex_left <= sr ? lbc_pkg::XSR_CYC - 1 : lbc_pkg::XP_CYC - 1;
      end else if (!cke_in) begin
        low_power_out <= 1'b1;
        sr <= (c == lbc_pkg::PIN_REF);
        if (c == lbc_pkg::PIN_BST) begin
          open <= 4'h0;
          need_init <= 1'b1;
        end
        if ((c == lbc_pkg::PIN_REF || c == lbc_pkg::PIN_BST) && open != 0)
          viol_out <= viol_out + 8'h01;
        if (c inside {lbc_pkg::PIN_ACT, lbc_pkg::PIN_RD, lbc_pkg::PIN_WR,
            lbc_pkg::PIN_PRE, lbc_pkg::PIN_LMR})
          viol_out <= viol_out + 8'h01;
      end else begin
        // Both edges high: normal command rules apply
        if (c != 4'hF && c != 4'h7 && ex_left > 0)
          viol_out <= viol_out + 8'h01;
        case (c)
          lbc_pkg::PIN_ACT: begin
            if (open[ba_in] || need_init) viol_out <= viol_out + 8'h01;
            open[ba_in] <= 1'b1;
          end
          lbc_pkg::PIN_RD: begin
            if (!open[ba_in] || wr_left > 0)
              viol_out <= viol_out + 8'h01;
            rd_left <= CAS_LAT + BURST_LEN / 2 - 1;
            if (addr_in[10]) open[ba_in] <= 1'b0;
          end
          lbc_pkg::PIN_WR: begin
            if (!open[ba_in] || rd_left > 0)
              viol_out <= viol_out + 8'h01;
            wr_left <= BURST_LEN / 2 + lbc_pkg::WTR_CK;
            if (addr_in[10]) open[ba_in] <= 1'b0;
          end
          lbc_pkg::PIN_PRE: begin
            if (addr_in[10]) open <= 4'h0;
            else open[ba_in] <= 1'b0;
          end
          lbc_pkg::PIN_REF, lbc_pkg::PIN_LMR: begin
            if (open != 0) viol_out <= viol_out + 8'h01;
            if (c == lbc_pkg::PIN_LMR) need_init <= 1'b0;
          end
          lbc_pkg::PIN_BST: rd_left <= 0;
          default: ;
        endcase
      end
    end
  end
endmodule : lbc_dev_model

/* verification/tb.sv */
// Self-checking bench for the DRAM host controller
`timescale 1ns/1ps
module tb;
  localparam int BURST_LEN = 4;
  localparam int CAS_LAT = 3;
  logic clk_in, rstn_in, req_valid_in, req_ap_in, req_done_out;
  logic [3:0] req_cmd_in, req_mask_in, write_byte_mask_out, pins;
  logic [1:0] req_bank_in, ba_out;
  logic [12:0] req_addr_in, addr_out;
  logic cke_out, cs_n_out, ras_n_out, cas_n_out, we_n_out, need_init_out;
  logic [2:0] pwr_state_out;
  logic dev_lp;
  logic [7:0] dev_viol;
  int miscompares, total_checks, cyc, t_done, t0, n;
  assign pins = {cs_n_out, ras_n_out, cas_n_out, we_n_out};

  lbc_ctrl #(.BURST_LEN(BURST_LEN), .CAS_LAT(CAS_LAT), .NB(4)) u_dut (
    .clk_in(clk_in),
    .rstn_in(rstn_in), .req_valid_in(req_valid_in),
    .req_cmd_in(req_cmd_in), .req_bank_in(req_bank_in),
    .req_ap_in(req_ap_in), .req_addr_in(req_addr_in),
    .req_mask_in(req_mask_in), .req_done_out(req_done_out),
    .cke_out(cke_out), .cs_n_out(cs_n_out), .ras_n_out(ras_n_out),
    .cas_n_out(cas_n_out), .we_n_out(we_n_out), .ba_out(ba_out),
    .addr_out(addr_out), .write_byte_mask_out(write_byte_mask_out),
    .pwr_state_out(pwr_state_out), .need_init_out(need_init_out));
  lbc_dev_model #(.BURST_LEN(BURST_LEN), .CAS_LAT(CAS_LAT)) u_dev (
    .clk_in(clk_in),
    .rstn_in(rstn_in), .cke_in(cke_out), .cs_n_in(cs_n_out),
    .ras_n_in(ras_n_out), .cas_n_in(cas_n_out), .we_n_in(we_n_out),
    .ba_in(ba_out), .addr_in(addr_out), .low_power_out(dev_lp),
    .viol_out(dev_viol));

  // ------------------------------------------------------------
  // Clock, cycle count and watchdog
  // ------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial cyc = 0;
  always @(posedge clk_in) cyc <= cyc + 1;
  initial begin
    #(100 * 20000);
    miscompares++;
    $display("ERROR %0t: watchdog expired", $time);
    finish_test();
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("ERROR %0t: %s", $time, msg);
    end
  endtask : check

  task automatic issue(input logic [3:0] c, input logic [1:0] b,
                       input logic ap, input logic [3:0] m);
    int k;
    @(posedge clk_in);
    #1;
    req_cmd_in = c;
    req_bank_in = b;
    req_ap_in = ap;
    req_mask_in = m;
    req_addr_in = req_addr_in + 13'h0011;
    req_valid_in = 1'b1;
    k = 0;
    do begin
      @(posedge clk_in);
      #1;
      k++;
    end while (req_done_out !== 1'b1 && k < 300);
    req_valid_in = 1'b0;
    t_done = cyc;
    check(req_done_out === 1'b1, "request never issued");
  endtask : issue

  task automatic wake(output int exit_n);
    issue(4'hC, 2'h0, 1'b0, 4'h0);
    check(cke_out === 1'b1 && pwr_state_out === 3'h4, "no exit");
    exit_n = 0;
    while (pwr_state_out !== 3'h0 && exit_n < 100) begin
      check(cs_n_out === 1'b1 || pins === 4'h7, "command in exit");
      @(posedge clk_in);
      #1;
      exit_n++;
    end
  endtask : wake

  task automatic init_seq();
    issue(4'h5, 2'h0, 1'b0, 4'h0);
    check(pins === lbc_pkg::PIN_PRE && addr_out[10] === 1'b1, "prea");
    issue(4'h6, 2'h0, 1'b0, 4'h0);
    check(pins === lbc_pkg::PIN_REF, "refresh code");
    issue(4'h7, 2'h0, 1'b0, 4'h0);
    check(pins === lbc_pkg::PIN_LMR, "mode load code");
    issue(4'hD, 2'h0, 1'b0, 4'h0);
    @(posedge clk_in);
    #1;
    check(need_init_out === 1'b0, "init flag stuck");
  endtask : init_seq

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    check(cke_out === 1'b1 && pins === 4'h7, "reset pins");
    check(need_init_out === 1'b1 && pwr_state_out === 3'h0,
      "reset state");
    check(write_byte_mask_out === 4'h0, "reset mask");
  endtask : t_reset

  task automatic t_banks();
    issue(4'h1, 2'h0, 1'b0, 4'h0);
    issue(4'h1, 2'h1, 1'b0, 4'h0);
    check(pins === lbc_pkg::PIN_ACT && ba_out === 2'h1, "act b1");
    check(addr_out === req_addr_in, "row address");
    issue(4'h2, 2'h0, 1'b0, 4'h0);
    check(pins === lbc_pkg::PIN_RD && addr_out[10] === 1'b0, "read");
    t0 = t_done;
    issue(4'h3, 2'h1, 1'b0, 4'hA);
    check(t_done - t0 >= CAS_LAT + BURST_LEN / 2, "read to write gap");
    check(write_byte_mask_out === 4'hA, "write mask");
    t0 = t_done;
    @(posedge clk_in);
    #1;
    check(write_byte_mask_out === 4'h0, "mask not cleared");
    issue(4'h2, 2'h0, 1'b1, 4'h0);
    check(t_done - t0 >= BURST_LEN / 2 + 2, "write to read gap");
    check(addr_out[10] === 1'b1, "read auto precharge flag");
    t0 = t_done;
    issue(4'h3, 2'h1, 1'b1, 4'h3);
    check(t_done - t0 >= CAS_LAT + BURST_LEN / 2,
      "read ap to write gap");
    // The auto-closed bank must refuse a read: hold it and see nothing go
    @(posedge clk_in);
    #1;
    req_cmd_in = 4'h2;
    req_bank_in = 2'h1;
    req_ap_in = 1'b0;
    req_valid_in = 1'b1;
    repeat (12) begin
      @(posedge clk_in);
      #1;
      check(req_done_out === 1'b0, "read to auto-closed bank issued");
    end
    req_valid_in = 1'b0;
  endtask : t_banks

  task automatic t_bst();
    issue(4'h1, 2'h0, 1'b0, 4'h0);
    issue(4'h2, 2'h0, 1'b0, 4'h0);
    t0 = t_done;
    issue(4'h8, 2'h0, 1'b0, 4'h0);
    check(pins === lbc_pkg::PIN_BST, "burst stop code");
    issue(4'h3, 2'h0, 1'b0, 4'h5);
    check(t_done - t0 < CAS_LAT + BURST_LEN / 2, "bst write late");
    issue(4'h1, 2'h1, 1'b0, 4'h0);
    check(pins === lbc_pkg::PIN_ACT && ba_out === 2'h1,
      "act during write");
  endtask : t_bst

  task automatic t_power();
    issue(4'h9, 2'h0, 1'b0, 4'h0);
    check(cke_out === 1'b0 && pwr_state_out === 3'h3, "active pd");
    repeat (4) @(posedge clk_in);
    #1;
    check(cke_out === 1'b0 && dev_lp === 1'b1, "pd not held");
    wake(n);
    check(n >= lbc_pkg::XP_CYC, "pd exit short");
    issue(4'h5, 2'h0, 1'b0, 4'h0);
    issue(4'h9, 2'h0, 1'b0, 4'h0);
    check(pwr_state_out === 3'h1 && cke_out === 1'b0, "pre pd");
    wake(n);
    issue(4'hA, 2'h0, 1'b0, 4'h0);
    check(pins === lbc_pkg::PIN_REF && cke_out === 1'b0, "sr entry");
    check(pwr_state_out === 3'h2, "sr state");
    repeat (3) @(posedge clk_in);
    wake(n);
    check(n >= lbc_pkg::XSR_CYC && n >= 2, "sr exit short");
    issue(4'hB, 2'h0, 1'b0, 4'h0);
    check(pins === lbc_pkg::PIN_BST && cke_out === 1'b0,
      "deep sleep entry");
    check(pwr_state_out === 3'h6, "deep sleep state");
    wake(n);
    check(need_init_out === 1'b1, "deep sleep wake no init");
    init_seq();
    issue(4'h1, 2'h2, 1'b0, 4'h0);
    check(pins === lbc_pkg::PIN_ACT && ba_out === 2'h2,
      "act after init");
  endtask : t_power

  task automatic finish_test();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  initial begin
    rstn_in = 1'b0;
    req_valid_in = 1'b0;
    req_cmd_in = 4'h0;
    req_bank_in = 2'h0;
    req_ap_in = 1'b0;
    req_addr_in = 13'h0100;
    req_mask_in = 4'h0;
    miscompares = 0;
    total_checks = 0;
    repeat (10) @(posedge clk_in);
    #1;
    rstn_in = 1'b1;
    t_reset();
    init_seq();
    t_banks();
    t_bst();
    t_power();
    check(dev_viol === 8'h00, "device saw illegal command");
    finish_test();
  end
endmodule : tb
